/* rtl/pmu_thermal_status_regs.sv */
// Operation
// - Discharge bit at 1 enables its output pull-down, at 0 disables.
// - Cooled from shutdown, enable pin high: start-up begins on its own.
// - Retention set: registers unchanged through shutdown and restart.
// - Retention clear: registers reload defaults before start-up.
// - Status shutdown bit reads 1 while in thermal shutdown.
// - Status warning bit reads 1 while above the early warning level.
// - Interrupt shutdown bit reads 1 after a shutdown interrupt.
// - Warning crossing pulls interrupt low and sets both warning bits.
// - Shutdown crossing triggers emergency shutdown of the outputs.
// - Power-up after shutdown only once cooled below recovery level.
`timescale 1ns/1ps
module pmu_thermal_status_regs
(
   input  wire logic                         core_clk,
   input  wire logic                         reset,
   input  wire logic                         scl_in,
   input  wire logic                         sda_in,
   output logic                              sda_out,
   output logic                              sda_oe_n,
   output logic                              irq_out,
   output logic                              irq_oe_n,
   input  wire logic                         en_pin,
   input  wire pmu_thermal_pkg::temp_sense_t temp,
   output logic [5:0]                        discharge_en,
   output logic                              outputs_off,
   output logic                              startup_pulse
);
   import pmu_thermal_pkg::*;
   function automatic logic [7:0] read_reg(input logic [7:0] a, c,
                                           input logic       s, w,
                                           input logic [1:0] f);
      case (a)
         CTRL_ADDR:   return c;
         STATUS_ADDR: return {6'h00, w, s};
         IRQ_ADDR:    return {6'h00, f};
         default:     return 8'h00;
      endcase
   endfunction
   therm_state_t  therm_reg, therm_next;
   logic [7:0]    ctrl_reg, ctrl_next;
   logic [1:0]    flags_reg, flags_next;
   logic          ew_status_reg, ew_status_next;
   logic          start_reg, start_next;
   logic          off_reg, off_next;
   logic          irq_n_reg, irq_n_next;
   serial_state_t sp_reg, sp_next;
   rx_kind_t      kind_reg, kind_next;
   logic [2:0]    cnt_reg, cnt_next;
   logic [7:0]    sh_reg, sh_next;
   logic [7:0]    ptr_reg, ptr_next;
   logic          rd_reg, rd_next;
   logic          ackon_reg, ackon_next;
   logic          sda_n_reg, sda_n_next;
   logic          scl_q_reg, sda_q_reg;
   logic          wr_en;
   logic [7:0]    wr_data;
   logic          rd_clr;
   logic scl_rise, scl_fall, start_cond, stop_cond;
   assign scl_rise   = scl_in & ~scl_q_reg;
   assign scl_fall   = ~scl_in & scl_q_reg;
   assign start_cond = scl_in & scl_q_reg & sda_q_reg & ~sda_in;
   assign stop_cond  = scl_in & scl_q_reg & ~sda_q_reg & sda_in;
   always_comb begin
      logic [7:0] byte_in, rbyte;
      byte_in    = {sh_reg[6:0], sda_in};
      rbyte      = read_reg(ptr_reg, ctrl_reg, therm_reg == TH_SHUT,
                            ew_status_reg, flags_reg);
      sp_next    = sp_reg;
      kind_next  = kind_reg;
      cnt_next   = cnt_reg;
      sh_next    = sh_reg;
      ptr_next   = ptr_reg;
      rd_next    = rd_reg;
      ackon_next = ackon_reg;
      sda_n_next = sda_n_reg;
      wr_en      = 1'b0;
      wr_data    = byte_in;
      rd_clr     = 1'b0;
      if (start_cond) begin
         sp_next    = SP_RX;
         kind_next  = RX_ADDR;
         cnt_next   = 3'h0;
         sda_n_next = 1'b1;
      end else if (stop_cond) begin
         sp_next    = SP_IDLE;
         sda_n_next = 1'b1;
      end else begin
         case (sp_reg)
            SP_RX: begin
               if (scl_rise) begin
                  sh_next  = byte_in;
                  cnt_next = cnt_reg + 3'h1;
                  if (cnt_reg == LAST_BIT) begin
                     sp_next    = SP_ACK;
                     ackon_next = 1'b0;
                     case (kind_reg)
                        RX_ADDR: begin
                           rd_next   = byte_in[0];
                           kind_next = RX_PTR;
                           if (byte_in[7:1] != DEV_ADDR)
                              sp_next = SP_IDLE;
                        end
                        RX_PTR: begin
                           ptr_next  = byte_in;
                           kind_next = RX_DATA;
                        end
                        default: begin
                           wr_en    = 1'b1;
                           ptr_next = ptr_reg + 8'h01;
                        end
                     endcase
                  end
               end
            end
            SP_ACK: begin
               if (scl_fall) begin
                  if (!ackon_reg) begin
                     ackon_next = 1'b1;
                     sda_n_next = 1'b0;
                  end else if (rd_reg) begin
                     sp_next    = SP_TX;
                     cnt_next   = 3'h0;
                     sda_n_next = rbyte[7];
                     sh_next    = {rbyte[6:0], 1'b0};
                     ptr_next   = ptr_reg + 8'h01;
                     rd_clr     = (ptr_reg == IRQ_ADDR);
                  end else begin
                     sp_next    = SP_RX;
                     cnt_next   = 3'h0;
                     sda_n_next = 1'b1;
                  end
               end
            end
            SP_TX: begin
               if (scl_fall) begin
                  sda_n_next = sh_reg[7];
                  sh_next    = {sh_reg[6:0], 1'b0};
               end else if (scl_rise) begin
                  cnt_next = cnt_reg + 3'h1;
                  if (cnt_reg == LAST_BIT)
                     sp_next = SP_RACK;
               end
            end
            SP_RACK: begin
               if (scl_fall) begin
                  sda_n_next = 1'b1;
               end else if (scl_rise) begin
                  if (sda_in) begin
                     sp_next = SP_IDLE;
                  end else begin
                     sp_next  = SP_TX;
                     cnt_next = 3'h0;
                     sh_next  = rbyte;
                     ptr_next = ptr_reg + 8'h01;
                     rd_clr   = (ptr_reg == IRQ_ADDR);
                  end
               end
            end
            default: sp_next = SP_IDLE;
         endcase
      end
   end
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         sp_reg    <= SP_IDLE;
         kind_reg  <= RX_ADDR;
         cnt_reg   <= 3'h0;
         sh_reg    <= 8'h00;
         ptr_reg   <= 8'h00;
         rd_reg    <= 1'b0;
         ackon_reg <= 1'b0;
         sda_n_reg <= 1'b1;
         scl_q_reg <= 1'b1;
         sda_q_reg <= 1'b1;
      end else begin
         sp_reg    <= sp_next;
         kind_reg  <= kind_next;
         cnt_reg   <= cnt_next;
         sh_reg    <= sh_next;
         ptr_reg   <= ptr_next;
         rd_reg    <= rd_next;
         ackon_reg <= ackon_next;
         sda_n_reg <= sda_n_next;
         scl_q_reg <= scl_in;
         sda_q_reg <= sda_in;
      end
   end
   always_comb begin
      logic cooled;
      logic [1:0] set_bits;
      cooled         = temp.below_recover & en_pin;
      therm_next     = therm_reg;
      start_next     = 1'b0;
      ctrl_next      = ctrl_reg;
      set_bits       = 2'h0;
      // Status bit doubles as the last sample for the warning edge
      ew_status_next = temp.above_warn;
      if (wr_en && ptr_reg == CTRL_ADDR)
         ctrl_next = wr_data & CTRL_MASK;
      if (temp.above_warn && !ew_status_reg)
         set_bits[WARN_BIT] = 1'b1;
      // Clear only what the host saw; a new event in that cycle survives
      flags_next = flags_reg & ~(rd_clr ? flags_reg : 2'h0);
      case (therm_reg)
         TH_RUN: begin
            if (temp.above_shutdown) begin
               therm_next         = TH_SHUT;
               set_bits[SHUT_BIT] = 1'b1;
            end
         end
         TH_SHUT: begin
            if (cooled && !temp.above_shutdown) begin
               therm_next = TH_RUN;
               start_next = 1'b1;
               if (!ctrl_reg[KEEP_BIT]) begin
                  ctrl_next  = CTRL_RESET;
                  flags_next = FLAGS_RESET;
               end
            end
         end
         default: therm_next = TH_RUN;
      endcase
      flags_next = flags_next | set_bits;
      off_next   = (therm_next == TH_SHUT);
      irq_n_next = ~|flags_next;
   end
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         therm_reg     <= TH_RUN;
         ctrl_reg      <= CTRL_RESET;
         flags_reg     <= FLAGS_RESET;
         ew_status_reg <= 1'b0;
         start_reg     <= 1'b0;
         off_reg       <= 1'b0;
         irq_n_reg     <= 1'b1;
      end else begin
         therm_reg     <= therm_next;
         ctrl_reg      <= ctrl_next;
         flags_reg     <= flags_next;
         ew_status_reg <= ew_status_next;
         start_reg     <= start_next;
         off_reg       <= off_next;
         irq_n_reg     <= irq_n_next;
      end
   end
   assign sda_out       = 1'b0;
   assign sda_oe_n      = sda_n_reg;
   assign irq_out       = 1'b0;
   assign irq_oe_n      = irq_n_reg;
   assign discharge_en  = ctrl_reg[DISCH_LSB +: DISCH_W];
   assign outputs_off   = off_reg;
   assign startup_pulse = start_reg;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);
   a_discharge_follow: assert property (
      therm_reg == TH_RUN && wr_en && ptr_reg == CTRL_ADDR
      |=> discharge_en == $past(wr_data[DISCH_LSB +: DISCH_W]))
      else $error("Discharge enables differ from written value");
   a_restart_start: assert property (
      therm_reg == TH_SHUT && temp.below_recover && en_pin
      && !temp.above_shutdown |=> startup_pulse && !outputs_off)
      else $error("No start-up after cooling");
   a_keep_regs: assert property (
      therm_reg == TH_SHUT && ctrl_reg[KEEP_BIT] && !wr_en
      |=> $stable(ctrl_reg))
      else $error("Registers changed with retention set");
   a_reload_default: assert property (
      therm_reg == TH_SHUT && !ctrl_reg[KEEP_BIT] && temp.below_recover
      && en_pin && !temp.above_shutdown |=> ctrl_reg == CTRL_RESET)
      else $error("Registers not reloaded on restart");
   a_status_shut: assert property (
      therm_reg == TH_RUN && temp.above_shutdown
      |=> read_reg(STATUS_ADDR, ctrl_reg, therm_reg == TH_SHUT,
                   ew_status_reg, flags_reg) == {6'h00, ew_status_reg, 1'b1})
      else $error("Status shutdown bit not set");
   a_status_warn: assert property (
      temp.above_warn ##1 temp.above_warn |-> ew_status_reg)
      else $error("Status warning bit not set");
   a_shut_irq: assert property (
      therm_reg == TH_RUN && temp.above_shutdown
      |=> flags_reg[SHUT_BIT] && !irq_oe_n)
      else $error("Shutdown interrupt missing");
   a_warn_irq: assert property (
      $rose(temp.above_warn) |=> flags_reg[WARN_BIT] && !irq_oe_n)
      else $error("Warning interrupt missing");
   a_shut_outputs: assert property (
      therm_reg == TH_RUN && temp.above_shutdown |=> outputs_off)
      else $error("Outputs not shut down");
   a_hot_hold: assert property (
      therm_reg == TH_SHUT && !temp.below_recover
      |=> therm_reg == TH_SHUT && !startup_pulse)
      else $error("Power-up before cooling");
   a_irq_release: assert property (flags_reg == 2'h0 |-> irq_oe_n)
      else $error("Interrupt held with no flag");
endmodule

/* shared/pmu_thermal_pkg.sv */
package pmu_thermal_pkg;
   // Register map
   localparam logic [7:0] CTRL_ADDR     = 8'h09;
   localparam logic [7:0] STATUS_ADDR   = 8'h0a;
   localparam logic [7:0] IRQ_ADDR      = 8'h0b;
   // Control fields
   localparam int         DISCH_LSB     = 0;
   localparam int         DISCH_W       = 6;
   localparam int         KEEP_BIT      = 6;
   localparam logic [7:0] CTRL_RESET    = 8'h00;
   localparam logic [7:0] CTRL_MASK     = 8'h7f;
   // Status and interrupt fields
   localparam int         SHUT_BIT      = 0;
   localparam int         WARN_BIT      = 1;
   localparam logic [1:0] FLAGS_RESET   = 2'h0;
   // Serial port
   localparam logic [6:0] DEV_ADDR      = 7'h5a; // Arbitrary value
   localparam logic [2:0] LAST_BIT      = 3'h7;

   typedef struct packed {
      logic above_warn;
      logic above_shutdown;
      logic below_recover;
   } temp_sense_t;

   typedef enum logic [1:0] {
      TH_RUN  = 2'b00,
      TH_SHUT = 2'b01
   } therm_state_t;

   typedef enum logic [2:0] {
      SP_IDLE = 3'b000,
      SP_RX   = 3'b001,
      SP_ACK  = 3'b010,
      SP_TX   = 3'b011,
      SP_RACK = 3'b100
   } serial_state_t;

   typedef enum logic [1:0] {
      RX_ADDR = 2'b00,
      RX_PTR  = 2'b01,
      RX_DATA = 2'b10
   } rx_kind_t;
endpackage

/* verif/host_model.sv */
`timescale 1ns/1ps
module host_model
   import pmu_thermal_pkg::*;
(
   input  wire logic core_clk,
   input  wire logic sda_oe_n,
   output logic      scl,
   output logic      sda_line
);
   logic sda_drv;
   // Wired-and with pull-up: released line reads high
   assign sda_line = sda_drv & sda_oe_n;
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   // Also serves as repeated start from scl low
   task automatic start();
      tick(2);
      sda_drv <= 1'b1;
      tick(2);
      scl <= 1'b1;
      tick(4);
      sda_drv <= 1'b0;
      tick(4);
      scl <= 1'b0;
   endtask
   task automatic stop();
      tick(2);
      sda_drv <= 1'b0;
      tick(2);
      scl <= 1'b1;
      tick(4);
      sda_drv <= 1'b1;
      tick(4);
   endtask
   // Eight data bits MSB first, then the ack slot
   task automatic xfer(input logic [7:0] tx, input logic mack,
                       output logic [7:0] rx, output logic ack);
      for (int i = 0; i < 9; i++) begin
         tick(2);
         sda_drv <= (i < 8) ? tx[7 - i] : mack;
         tick(2);
         scl <= 1'b1;
         tick(2);
         if (i < 8) rx[7 - i] = sda_line;
         else ack = sda_line;
         tick(2);
         scl <= 1'b0;
      end
   endtask
   task automatic wr(input logic [7:0] ptr, input logic [7:0] d,
                     output logic ok);
      logic [7:0] r;
      logic       a0, a1, a2;
      start();
      xfer({DEV_ADDR, 1'b0}, 1'b1, r, a0);
      xfer(ptr, 1'b1, r, a1);
      xfer(d, 1'b1, r, a2);
      stop();
      ok = ~(a0 | a1 | a2);
   endtask
   task automatic rd(input logic [6:0] dev, input logic [7:0] ptr,
                     output logic [7:0] d, output logic ok);
      logic [7:0] r;
      logic       a0, a1, a2, a3;
      start();
      xfer({dev, 1'b0}, 1'b1, r, a0);
      xfer(ptr, 1'b1, r, a1);
      start();
      xfer({dev, 1'b1}, 1'b1, r, a2);
      // Master NACK ends the read
      xfer(8'hff, 1'b1, d, a3);
      stop();
      ok = ~(a0 | a1 | a2);
   endtask
endmodule

/* verif/tb.sv */
`timescale 1ns/1ps
`define CHK(a, e) chk(8'(a), 8'(e))
module tb;
   import pmu_thermal_pkg::*;
   logic        core_clk = 1'b0;
   logic        reset = 1'b1;
   logic        en_pin = 1'b1;
   temp_sense_t temp;
   logic        scl, sda, sda_out, sda_oe_n, irq_out, irq_oe_n;
   logic [5:0]  discharge_en;
   logic        outputs_off, startup_pulse, ok;
   logic [7:0]  d;
   int          num_errors = 0;
   int          comparisons = 0;
   always #25 core_clk = ~core_clk;
   host_model host_model_inst (.core_clk(core_clk), .sda_oe_n(sda_oe_n),
                               .scl(scl), .sda_line(sda));
   pmu_thermal_status_regs pmu_thermal_status_regs_inst (
      .core_clk(core_clk), .reset(reset), .scl_in(scl), .sda_in(sda),
      .sda_out(sda_out), .sda_oe_n(sda_oe_n), .irq_out(irq_out),
      .irq_oe_n(irq_oe_n), .en_pin(en_pin), .temp(temp),
      .discharge_en(discharge_en), .outputs_off(outputs_off),
      .startup_pulse(startup_pulse));
   task automatic chk(input logic [7:0] a, input logic [7:0] e);
      comparisons++;
      if (a !== e) begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, a, e);
      end
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge core_clk);
      @(negedge core_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      host_model_inst.wr(a, v, ok);
      `CHK(ok, 1'b1);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      host_model_inst.rd(DEV_ADDR, a, d, ok);
      `CHK(ok, 1'b1);
      `CHK(d, e);
   endtask
   task automatic t_regs();
      wr(CTRL_ADDR, 8'hff);
      rd_chk(CTRL_ADDR, 8'h7f);
      `CHK(discharge_en, 6'h3f);
      wr(CTRL_ADDR, 8'h15);
      `CHK(discharge_en, 6'h15);
      wr(8'h0c, 8'h55);
      rd_chk(8'h0c, 8'h00);
      // Foreign address must get no ack
      host_model_inst.rd(7'h2b, CTRL_ADDR, d, ok);
      `CHK(ok, 1'b0);
      $display("register test done");
   endtask
   task automatic t_warn();
      @(posedge core_clk);
      temp.above_warn <= 1'b1;
      settle(3);
      `CHK(irq_oe_n, 1'b0);
      `CHK(irq_out, 1'b0);
      rd_chk(STATUS_ADDR, 8'h02);
      rd_chk(IRQ_ADDR, 8'h02);
      `CHK(irq_oe_n, 1'b1);
      rd_chk(IRQ_ADDR, 8'h00);
      @(posedge core_clk);
      temp.above_warn <= 1'b0;
      settle(3);
      rd_chk(STATUS_ADDR, 8'h00);
      $display("warning test done");
   endtask
   task automatic t_shut(input logic keep);
      int n;
      wr(CTRL_ADDR, {1'b0, keep, 6'h2a});
      @(posedge core_clk);
      temp <= 3'b010;
      settle(3);
      `CHK(outputs_off, 1'b1);
      `CHK(irq_oe_n, 1'b0);
      rd_chk(STATUS_ADDR, 8'h01);
      rd_chk(IRQ_ADDR, 8'h01);
      @(posedge core_clk);
      temp <= 3'b000;
      settle(6);
      `CHK(outputs_off, 1'b1);
      // Cooled but enable pin low: must stay down
      @(posedge core_clk);
      en_pin <= 1'b0;
      temp <= 3'b001;
      settle(6);
      `CHK(outputs_off, 1'b1);
      @(posedge core_clk);
      en_pin <= 1'b1;
      n = 0;
      @(negedge core_clk);
      while (startup_pulse !== 1'b1 && n < 8) begin
         @(negedge core_clk);
         n++;
      end
      `CHK(startup_pulse, 1'b1);
      settle(1);
      `CHK(startup_pulse, 1'b0);
      `CHK(outputs_off, 1'b0);
      rd_chk(CTRL_ADDR, keep ? 8'h6a : CTRL_RESET);
      `CHK(discharge_en, keep ? 6'h2a : 6'h00);
      rd_chk(STATUS_ADDR, 8'h00);
      $display("shutdown test done, retention %0b", keep);
   endtask
   task automatic results();
      $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      temp = 3'b001;
      repeat (2) @(posedge core_clk);
      reset <= 1'b0;
      repeat (2) @(posedge core_clk);
      t_regs();
      t_warn();
      t_shut(1'b1);
      t_shut(1'b0);
      results();
   end
   // Run needs about 6100 cycles; limit is 40000
   initial begin
      #2000000;
      num_errors++;
      results();
   end
endmodule
